// *** hdl/lfs_consts.vh ***
// Notes on behaviour
// (R01) eight linefeed states, host picks one by writing the state register
// (R02) after reset the line sits in the open state
// (R03) a fault or overpower forces open and raises the matching alarm bit (power, foreign or thermal)
// (R04) alarm interrupt maskable; mask never stops the protective fallback
// (R05) fallback sources: total power, foreign current/voltage, thermal
// (R06) thermal trip at 145 or 200 degrees, held shut by a hold-off delay
// (R07) all measurement registers refreshed at 2 kHz or faster
// (R08) loop voltage, loop current, longitudinal current derived and stored apart
// (R09) open: leads high impedance, supervision and audio powered down
// (R10) host uses open for switch intervals, faults and diagnostics
// (R11) active states: feed, audio, loop and ground key detect; polarity per state
// (R12) on-hook transmission: feed and audio on, polarity as in active
// (R13) tip open: ring driven, tip floats, detection active
// (R14) ring open: tip driven, ring floats, detection active
// (R15) ringing: ring signal on both leads, dc offset as configured
// (R16) diagnostics: channel in test mode with test resources
// (R17) control over the register port, voice samples on a separate bus
// (R18) wideband selection runs audio at 16 kHz instead of 8 kHz
// (R19) wideband sample pair spans two consecutive 8 kHz frames
// (R20) state field three bits; fallback writes the open code back
// (R21) alarm flag sticky until host clears it; mask gates only the output
`ifndef LFS_CONSTS_VH
`define LFS_CONSTS_VH

// register offsets
`define LFS_ADDR_STATE   4'h0
`define LFS_ADDR_CFG     4'h1
`define LFS_ADDR_ALARM   4'h2
`define LFS_ADDR_MASK    4'h3
`define LFS_ADDR_VTIP    4'h4
`define LFS_ADDR_VRING   4'h5
`define LFS_ADDR_ITIP    4'h6
`define LFS_ADDR_IRING   4'h7
`define LFS_ADDR_VLOOP   4'h8
`define LFS_ADDR_ILOOP   4'h9
`define LFS_ADDR_ILONG   4'ha
`define LFS_ADDR_STATUS  4'hb

// state codes
`define LFS_ST_OPEN      3'h0
`define LFS_ST_FWD_ACT   3'h1
`define LFS_ST_FWD_OHT   3'h2
`define LFS_ST_TIP_OPEN  3'h3
`define LFS_ST_RINGING   3'h4
`define LFS_ST_REV_ACT   3'h5
`define LFS_ST_REV_OHT   3'h6
`define LFS_ST_RING_OPEN 3'h7

// config bit positions
`define LFS_CFG_WIDEBAND 0
`define LFS_CFG_RING_DC  1
`define LFS_CFG_TRIP200  2
`define LFS_CFG_DIAG     3
`define LFS_CFG_RST      4'h0

// alarm bit positions
`define LFS_AL_POWER     0
`define LFS_AL_FOREIGN   1
`define LFS_AL_THERMAL   2

// timing
`define LFS_CLK_HZ       100000000
`define LFS_REFRESH_HZ   2000
`define LFS_REFRESH_CYC  (`LFS_CLK_HZ / `LFS_REFRESH_HZ)
`define LFS_FRAME_HZ     8000
`define LFS_FRAME_CYC    (`LFS_CLK_HZ / `LFS_FRAME_HZ)
`define LFS_THERM_HOLD_MS 1000
`define LFS_THERM_HOLD_CYC (`LFS_CLK_HZ / 1000 * `LFS_THERM_HOLD_MS)
`define LFS_TEMP_145     8'h91
`define LFS_TEMP_200     8'hc8

`endif

// *** hdl/lfs_divider.v ***
`timescale 1ns/100ps
`include "lfs_consts.vh"
// one-cycle enable every div clocks
module lfs_divider #(
   parameter DIV = 2
) (
   input  wire        clk,
   input  wire        arst_n,
   output reg         tick
);
   reg [31:0] count;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= 32'h0000_0000;
         tick  <= 1'b0;
      end else if (count == DIV - 1) begin
         count <= 32'h0000_0000;
         tick  <= 1'b1;
      end else begin
         count <= count + 32'h0000_0001;
         tick  <= 1'b0;
      end
   end
endmodule

// *** hdl/lfs_monitor.v ***
`timescale 1ns/100ps
`include "lfs_consts.vh"
// --------------------------------------------------
// measurement store
// --------------------------------------------------
module lfs_monitor (
   input  wire               clk,
   input  wire               arst_n,
   input  wire               sample,
   input  wire signed [15:0] adc_vtip,
   input  wire signed [15:0] adc_vring,
   input  wire signed [15:0] adc_itip,
   input  wire signed [15:0] adc_iring,
   output reg  [15:0]        vtip,
   output reg  [15:0]        vring,
   output reg  [15:0]        itip,
   output reg  [15:0]        iring,
   output reg  [15:0]        vloop,
   output reg  [15:0]        iloop,
   output reg  [15:0]        ilong
);
   wire signed [16:0] sum_i  = adc_itip + adc_iring;
   wire signed [16:0] diff_i = adc_itip - adc_iring;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         vtip  <= 16'h0000;
         vring <= 16'h0000;
         itip  <= 16'h0000;
         iring <= 16'h0000;
         vloop <= 16'h0000;
         iloop <= 16'h0000;
         ilong <= 16'h0000;
      end else if (sample) begin                                     // (R07)
         vtip  <= adc_vtip;
         vring <= adc_vring;
         itip  <= adc_itip;
         iring <= adc_iring;
         vloop <= adc_vtip - adc_vring;                              // (R08)
         // halved so the metallic and common-mode parts never overflow
         iloop <= diff_i[16:1];                                      // (R08)
         ilong <= sum_i[16:1];                                       // (R08)
      end
   end
endmodule

// *** hdl/lfs_supervisor.v ***
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
`include "lfs_consts.vh"
module lfs_supervisor #(
   parameter THERM_HOLD_CYC = `LFS_THERM_HOLD_CYC
) (
   input  wire        clk,
   input  wire        arst_n,
   // register port
   input  wire [3:0]  addr,
   input  wire [15:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [15:0] rdata,
   // fault sensors
   input  wire        over_power,
   input  wire        foreign_fault,
   input  wire [7:0]  die_temp,
   // monitor inputs
   input  wire [15:0] adc_vtip,
   input  wire [15:0] adc_vring,
   input  wire [15:0] adc_itip,
   input  wire [15:0] adc_iring,
   // line controls
   output reg         tip_drive,
   output reg         ring_drive,
   output reg         polarity_rev,
   output reg         feed_en,
   output reg         audio_en,
   output reg         detect_en,
   output reg         ring_en,
   output reg         ring_dc_en,
   output reg         diag_en,
   output reg         thermal_shutdown,
   output reg         wideband,
   output reg         pcm_frame_half,
   output wire        irq_n
);
   // ----------------------------------------------
   // registers
   // ----------------------------------------------
   reg  [2:0] line_state;
   reg  [3:0] cfg;
   reg  [2:0] alarm;
   reg  [2:0] mask;
   reg [31:0] hold_cnt;
   reg  [2:0] next_line_state;
   reg  [2:0] next_alarm;
   wire       tick_2k;
   wire       tick_8k;
   wire [15:0] m_vtip, m_vring, m_itip, m_iring, m_vloop, m_iloop, m_ilong;

   wire [7:0] trip_level = cfg[`LFS_CFG_TRIP200] ? `LFS_TEMP_200 : `LFS_TEMP_145; // (R06)
   wire       over_temp  = die_temp >= trip_level;
   wire       therm_evt  = over_temp & ~thermal_shutdown;
   wire [2:0] events     = {therm_evt, foreign_fault, over_power};              // (R05)
   wire       fault      = |events;
   wire       wr_state   = wr & (addr == `LFS_ADDR_STATE);
   wire       wr_alarm   = wr & (addr == `LFS_ADDR_ALARM);

   lfs_divider #(.DIV(`LFS_REFRESH_CYC)) u_div2k (
      .clk    (clk),
      .arst_n (arst_n),
      .tick   (tick_2k)
   );
   lfs_divider #(.DIV(`LFS_FRAME_CYC)) u_div8k (
      .clk    (clk),
      .arst_n (arst_n),
      .tick   (tick_8k)
   );
   lfs_monitor u_mon (
      .clk       (clk),
      .arst_n    (arst_n),
      .sample    (tick_2k),
      .adc_vtip  (adc_vtip),
      .adc_vring (adc_vring),
      .adc_itip  (adc_itip),
      .adc_iring (adc_iring),
      .vtip      (m_vtip),
      .vring     (m_vring),
      .itip      (m_itip),
      .iring     (m_iring),
      .vloop     (m_vloop),
      .iloop     (m_iloop),
      .ilong     (m_ilong)
   );

   // ----------------------------------------------
   // state and alarm update
   // ----------------------------------------------
   always @* begin
      next_line_state = line_state;
      if (wr_state)
         next_line_state = wdata[2:0];                               // (R01)
      // fallback wins over a host write and ignores the mask
      if (fault)
         next_line_state = `LFS_ST_OPEN;                             // (R03) (R20) (R04)
      next_alarm = alarm;
      if (wr_alarm)
         next_alarm = alarm & ~wdata[2:0];
      next_alarm = next_alarm | events;                              // (R21)
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         line_state <= `LFS_ST_OPEN;                                 // (R02)
         cfg        <= `LFS_CFG_RST;
         alarm      <= 3'h0;
         mask       <= 3'h0;
      end else begin
         line_state <= next_line_state;
         alarm      <= next_alarm;
         if (wr & (addr == `LFS_ADDR_CFG))
            cfg <= wdata[3:0];
         if (wr & (addr == `LFS_ADDR_MASK))
            mask <= wdata[2:0];
      end
   end

   assign irq_n = ~|(alarm & mask);                                  // (R04) (R21)

   // ----------------------------------------------
   // thermal shutdown with hold-off
   // ----------------------------------------------
   // a power cross heats and cools fast; the hold keeps us off through it
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         thermal_shutdown <= 1'b0;
         hold_cnt         <= 32'h0000_0000;
      end else if (over_temp) begin
         thermal_shutdown <= 1'b1;                                   // (R06)
         hold_cnt         <= THERM_HOLD_CYC;
      end else if (hold_cnt != 32'h0000_0000) begin
         hold_cnt <= hold_cnt - 32'h0000_0001;
      end else begin
         thermal_shutdown <= 1'b0;
      end
   end

   // ----------------------------------------------
   // line control decode
   // ----------------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tip_drive    <= 1'b0;
         ring_drive   <= 1'b0;
         polarity_rev <= 1'b0;
         feed_en      <= 1'b0;
         audio_en     <= 1'b0;
         detect_en    <= 1'b0;
         ring_en      <= 1'b0;
         ring_dc_en   <= 1'b0;
         diag_en      <= 1'b0;
      end else begin
         tip_drive    <= 1'b0;
         ring_drive   <= 1'b0;
         polarity_rev <= 1'b0;
         feed_en      <= 1'b0;
         audio_en     <= 1'b0;
         detect_en    <= 1'b0;
         ring_en      <= 1'b0;
         ring_dc_en   <= 1'b0;
         diag_en      <= 1'b0;
         case (line_state)
            `LFS_ST_FWD_ACT, `LFS_ST_REV_ACT: begin                  // (R11)
               tip_drive    <= 1'b1;
               ring_drive   <= 1'b1;
               feed_en      <= 1'b1;
               audio_en     <= 1'b1;
               detect_en    <= 1'b1;
               polarity_rev <= line_state == `LFS_ST_REV_ACT;
            end
            `LFS_ST_FWD_OHT, `LFS_ST_REV_OHT: begin                  // (R12)
               tip_drive    <= 1'b1;
               ring_drive   <= 1'b1;
               feed_en      <= 1'b1;
               audio_en     <= 1'b1;
               polarity_rev <= line_state == `LFS_ST_REV_OHT;
            end
            `LFS_ST_TIP_OPEN: begin                                  // (R13)
               ring_drive <= 1'b1;
               feed_en    <= 1'b1;
               detect_en  <= 1'b1;
            end
            `LFS_ST_RING_OPEN: begin                                 // (R14)
               tip_drive    <= 1'b1;
               feed_en      <= 1'b1;
               detect_en    <= 1'b1;
               polarity_rev <= 1'b1;
            end
            `LFS_ST_RINGING: begin                                   // (R15)
               tip_drive  <= 1'b1;
               ring_drive <= 1'b1;
               ring_en    <= 1'b1;
               ring_dc_en <= cfg[`LFS_CFG_RING_DC];
            end
            default: begin
               // open: everything stays off, leads float        (R09)
            end
         endcase
         // diagnostics shares the open code: high impedance while testing
         // only effective in open, so a test never meets a driven lead
         diag_en <= (line_state == `LFS_ST_OPEN) & cfg[`LFS_CFG_DIAG];  // (R16)
      end
   end

   // ----------------------------------------------
   // wideband framing
   // ----------------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wideband       <= 1'b0;
         pcm_frame_half <= 1'b0;
      end else begin
         wideband <= cfg[`LFS_CFG_WIDEBAND];                         // (R18)
         if (!cfg[`LFS_CFG_WIDEBAND])
            pcm_frame_half <= 1'b0;
         else if (tick_8k)
            pcm_frame_half <= ~pcm_frame_half;                       // (R19)
      end
   end

   // ----------------------------------------------
   // read port
   // ----------------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 16'h0000;
      end else if (rd) begin                                         // (R17)
         case (addr)
            `LFS_ADDR_STATE:  rdata <= {13'h0000, line_state};       // (R20)
            `LFS_ADDR_CFG:    rdata <= {12'h000, cfg};
            `LFS_ADDR_ALARM:  rdata <= {13'h0000, alarm};
            `LFS_ADDR_MASK:   rdata <= {13'h0000, mask};
            `LFS_ADDR_VTIP:   rdata <= m_vtip;
            `LFS_ADDR_VRING:  rdata <= m_vring;
            `LFS_ADDR_ITIP:   rdata <= m_itip;
            `LFS_ADDR_IRING:  rdata <= m_iring;
            `LFS_ADDR_VLOOP:  rdata <= m_vloop;
            `LFS_ADDR_ILOOP:  rdata <= m_iloop;
            `LFS_ADDR_ILONG:  rdata <= m_ilong;
            `LFS_ADDR_STATUS: rdata <= {13'h0000, pcm_frame_half, thermal_shutdown, over_temp};
            default:          rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end
endmodule

// *** verif/lfs_chk_properties.sv ***
`timescale 1ns/100ps
module lfs_chk #(
   parameter THERM_HOLD_CYC = 20
) (
   input wire        clk,
   input wire        arst_n,
   input wire [3:0]  addr,
   input wire [15:0] wdata,
   input wire        wr,
   input wire        over_power,
   input wire        foreign_fault,
   input wire [7:0]  die_temp,
   input wire        tip_drive,
   input wire        ring_drive,
   input wire        polarity_rev,
   input wire        feed_en,
   input wire        audio_en,
   input wire        detect_en,
   input wire        ring_en,
   input wire        thermal_shutdown,
   input wire        wideband
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // a state write only counts when no fault can override it
   wire calm = !over_power && !foreign_fault && die_temp < 8'h91;
   wire ws   = wr && addr == 4'h0 && calm;
   property p_open;
      ws && wdata[2:0] == 3'h0 |-> ##2 !(feed_en || audio_en || detect_en || tip_drive || ring_drive);
   endproperty
   a_open: assert property (p_open) else $error("open state not quiet");
   property p_fwd;
      ws && wdata[2:0] == 3'h1 |-> ##2 feed_en && audio_en && detect_en && !polarity_rev;
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward active wrong");
   property p_rev;
      ws && wdata[2:0] == 3'h5 |-> ##2 feed_en && audio_en && detect_en && polarity_rev;
   endproperty
   a_rev: assert property (p_rev) else $error("reverse active wrong");
   property p_oht;
      ws && wdata[1:0] == 2'h2 |-> ##2 feed_en && audio_en && polarity_rev == $past(wdata[2], 2);
   endproperty
   a_oht: assert property (p_oht) else $error("on-hook transmission wrong");
   property p_tip;
      ws && wdata[2:0] == 3'h3 |-> ##2 !tip_drive && ring_drive && detect_en;
   endproperty
   a_tip: assert property (p_tip) else $error("tip open wrong");
   property p_ring;
      ws && wdata[2:0] == 3'h7 |-> ##2 tip_drive && !ring_drive && detect_en;
   endproperty
   a_ring: assert property (p_ring) else $error("ring open wrong");
   property p_rng;
      ws && wdata[2:0] == 3'h4 |-> ##2 ring_en;
   endproperty
   a_rng: assert property (p_rng) else $error("ringing not applied");
   property p_fault;
      over_power || foreign_fault |-> ##2 !feed_en && !ring_en && !audio_en;
   endproperty
   a_fault: assert property (p_fault) else $error("fault did not force open");
   property p_therm;
      die_temp >= 8'hc8 |=> thermal_shutdown;
   endproperty
   a_therm: assert property (p_therm) else $error("no thermal shutdown");
   property p_hold;
      $rose(thermal_shutdown) |-> thermal_shutdown[*8];
   endproperty
   a_hold: assert property (p_hold) else $error("thermal shutdown not held");
   property p_wb;
      wr && addr == 4'h1 |-> ##2 wideband == $past(wdata[0], 2);
   endproperty
   a_wb: assert property (p_wb) else $error("wideband not following config");
   c_fault: cover property (over_power ##2 !feed_en);
   c_therm: cover property ($rose(thermal_shutdown));
   c_wb: cover property ($rose(wideband));
endmodule
bind lfs_supervisor lfs_chk #(.THERM_HOLD_CYC(THERM_HOLD_CYC)) u_chk (
   .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
   .over_power(over_power), .foreign_fault(foreign_fault), .die_temp(die_temp),
   .tip_drive(tip_drive), .ring_drive(ring_drive), .polarity_rev(polarity_rev),
   .feed_en(feed_en), .audio_en(audio_en), .detect_en(detect_en), .ring_en(ring_en),
   .thermal_shutdown(thermal_shutdown), .wideband(wideband));

// *** verif/lfs_host.sv ***
`timescale 1ns/100ps
// ------
// host on the register port
// ------
module lfs_host (
   input  wire        clk,
   output reg  [3:0]  addr,
   output reg  [15:0] wdata,
   output reg         wr,
   output reg         rd,
   input  wire [15:0] rdata
);
   initial begin
      addr = 4'h0;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
   end
   // all control travels here; idle lines show inverted values
   task write(input [3:0] a, input [15:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
         addr <= ~a;
         wdata <= ~d;
      end
   endtask
   task read(input [3:0] a, output [15:0] d);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         addr <= ~a;
         @(posedge clk);
         d = rdata;
      end
   endtask
endmodule

// *** verif/linefeed_state_fault_supervisor_tb.sv ***
`timescale 1ns/100ps
`include "lfs_consts.vh"
module linefeed_state_fault_supervisor_tb;
   reg         clk;
   reg         arst_n;
   reg         over_power;
   reg         foreign_fault;
   reg  [7:0]  die_temp;
   reg  [15:0] adc_vtip;
   reg  [15:0] adc_vring;
   reg  [15:0] adc_itip;
   reg  [15:0] adc_iring;
   wire [3:0]  addr;
   wire [15:0] wdata;
   wire        wr;
   wire        rd;
   wire [15:0] rdata;
   wire        tip_drive, ring_drive, polarity_rev, feed_en, audio_en, detect_en;
   wire        ring_en, thermal_shutdown, wideband, pcm_frame_half, irq_n;
   wire        ring_dc_en, diag_en;
   integer     n_mismatch, num_checks, cyc, i, c0;
   reg  [15:0] v;
   lfs_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   lfs_supervisor #(.THERM_HOLD_CYC(20)) DUT (
      .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .over_power(over_power), .foreign_fault(foreign_fault),
      .die_temp(die_temp), .adc_vtip(adc_vtip), .adc_vring(adc_vring),
      .adc_itip(adc_itip), .adc_iring(adc_iring), .tip_drive(tip_drive),
      .ring_drive(ring_drive), .polarity_rev(polarity_rev), .feed_en(feed_en),
      .audio_en(audio_en), .detect_en(detect_en), .ring_en(ring_en),
      .ring_dc_en(ring_dc_en), .diag_en(diag_en),
      .thermal_shutdown(thermal_shutdown), .wideband(wideband),
      .pcm_frame_half(pcm_frame_half), .irq_n(irq_n));
   // ------
   // helpers
   // ------
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", num_checks, n_mismatch);
         if (n_mismatch == 0 && num_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task rchk(input [3:0] a, input [15:0] exp);
      begin
         host.read(a, v);
         chk(v, exp);
      end
   endtask
   // fault held three cycles, then long enough for the thermal hold-off to lapse
   task hit(input [2:0] src, input [7:0] hot);
      begin
         @(posedge clk);
         over_power <= src[0];
         foreign_fault <= src[1];
         die_temp <= src[2] ? hot : 8'h19;
         repeat (3) @(posedge clk);
         over_power <= 1'b0;
         foreign_fault <= 1'b0;
         die_temp <= 8'h19;
         repeat (30) @(posedge clk);
      end
   endtask
   // ------
   // scenarios
   // ------
   task t_states;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            host.write(`LFS_ADDR_STATE, i[15:0]);
            rchk(`LFS_ADDR_STATE, i[15:0]);
         end
      end
   endtask
   task t_fault(input [15:0] mask);
      begin
         host.write(`LFS_ADDR_MASK, mask);
         for (i = 0; i < 3; i = i + 1) begin
            host.write(`LFS_ADDR_STATE, 16'h0005);
            hit(3'h1 << i, 8'h91);
            rchk(`LFS_ADDR_STATE, 16'h0000);
            rchk(`LFS_ADDR_ALARM, 16'h0001 << i);
            chk({15'h0000, irq_n}, mask[i] ? 16'h0000 : 16'h0001);
            host.write(`LFS_ADDR_ALARM, 16'h0001 << i);
            rchk(`LFS_ADDR_ALARM, 16'h0000);
            chk({15'h0000, irq_n}, 16'h0001);
         end
      end
   endtask
   task t_trip;
      begin
         host.write(`LFS_ADDR_CFG, 16'h0006);
         host.write(`LFS_ADDR_STATE, 16'h0004);
         hit(3'h4, 8'h91);
         rchk(`LFS_ADDR_STATE, 16'h0004);
         chk({14'h0000, ring_en, ring_dc_en}, 16'h0003);
         hit(3'h4, 8'hc8);
         rchk(`LFS_ADDR_STATE, 16'h0000);
         chk({14'h0000, ring_en, ring_dc_en}, 16'h0000);
         host.write(`LFS_ADDR_ALARM, 16'h0004);
         host.write(`LFS_ADDR_CFG, 16'h0000);
      end
   endtask
   task t_wide;
      begin
         host.write(`LFS_ADDR_CFG, 16'h0001);
         for (i = 0; i < 12600 && pcm_frame_half !== 1'b1; i = i + 1)
            @(posedge clk);
         chk({14'h0000, wideband, pcm_frame_half}, 16'h0003);
         for (i = 0; i < 13000 && pcm_frame_half === 1'b1; i = i + 1)
            @(posedge clk);
         chk(i[15:0], `LFS_FRAME_CYC);
         host.write(`LFS_ADDR_CFG, 16'h0000);
         repeat (2) @(posedge clk);
         chk({14'h0000, wideband, pcm_frame_half}, 16'h0000);
      end
   endtask
   task t_diag;
      begin
         host.write(`LFS_ADDR_STATE, 16'h0000);
         host.write(`LFS_ADDR_CFG, 16'h0008);
         repeat (2) @(posedge clk);
         chk({15'h0000, diag_en}, 16'h0001);
         chk({15'h0000, feed_en | tip_drive | ring_drive}, 16'h0000);
         rchk(`LFS_ADDR_CFG, 16'h0008);
         host.write(`LFS_ADDR_STATE, 16'h0001);
         repeat (2) @(posedge clk);
         chk({15'h0000, diag_en}, 16'h0000);
         host.write(`LFS_ADDR_CFG, 16'h0000);
         host.write(`LFS_ADDR_STATE, 16'h0000);
      end
   endtask
   task t_measure;
      begin
         @(posedge clk);
         adc_vtip <= 16'h03e8;
         adc_vring <= 16'h012c;
         adc_itip <= 16'h0064;
         adc_iring <= 16'h0028;
         v = 16'h0000;
         c0 = cyc;
         for (i = 0; i < 26000 && v !== 16'h02bc; i = i + 1)
            host.read(`LFS_ADDR_VLOOP, v);
         chk(v, 16'h02bc);
         chk({15'h0000, cyc - c0 <= `LFS_REFRESH_CYC + 8}, 16'h0001);
         rchk(`LFS_ADDR_VTIP, 16'h03e8);
         rchk(`LFS_ADDR_IRING, 16'h0028);
         rchk(`LFS_ADDR_ILOOP, 16'h001e);
         rchk(`LFS_ADDR_ILONG, 16'h0046);
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 90000) begin
         n_mismatch = n_mismatch + 1;
         stop_test;
      end
   end
   initial begin
      n_mismatch = 0;
      num_checks = 0;
      cyc = 0;
      arst_n = 1'b0;
      over_power = 1'b0;
      foreign_fault = 1'b0;
      die_temp = 8'h19;
      adc_vtip = 16'h0000;
      adc_vring = 16'h0000;
      adc_itip = 16'h0000;
      adc_iring = 16'h0000;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      rchk(`LFS_ADDR_STATE, 16'h0000);
      rchk(4'hf, 16'h0000);
      t_states;
      t_fault(16'h0007);
      t_fault(16'h0000);
      t_trip;
      t_wide;
      t_diag;
      t_measure;
      stop_test;
   end
endmodule
